// ==== hdl/lstab_dev.sv ====
// shared code tables behind axi4-lite plus soft-data input sink
// assumes a source that keeps byte counts and value order
`timescale 1ns/1ps
`default_nettype none
`include "lstab_defs.svh"
module lstab_dev
  import lstab_pkg::*;
#(
  parameter int SC_AW = `LSTAB_SC_AW,
  parameter int LA_AW = `LSTAB_LA_AW,
  parameter int QC_AW = `LSTAB_QC_AW
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // axi4-lite slave
  input  wire logic [17:0]  s_awaddr,
  input  wire logic         s_awvalid,
  output logic              s_awready,
  input  wire logic [31:0]  s_wdata,
  input  wire logic [3:0]   s_wstrb,
  input  wire logic         s_wvalid,
  output logic              s_wready,
  output logic [1:0]        s_bresp,
  output logic              s_bvalid,
  input  wire logic         s_bready,
  input  wire logic [17:0]  s_araddr,
  input  wire logic         s_arvalid,
  output logic              s_arready,
  output logic [31:0]       s_rdata,
  output logic [1:0]        s_rresp,
  output logic              s_rvalid,
  input  wire logic         s_rready,
  // core status
  input  wire logic         core_active,
  // table lookup by the core
  input  wire logic         lk_req,
  input  wire logic [8:0]   lk_layer,
  input  wire logic [12:0]  lk_op,
  output logic              lk_valid,
  output logic [3:0]        sc_factor,
  output logic [7:0]        la_stall,
  output logic              la_heavy,
  output logic [6:0]        la_cycles,
  output logic              qc_parity,
  output logic              qc_first,
  output logic [7:0]        qc_col,
  output logic [8:0]        qc_rot,
  output logic              qc_noop,
  output logic              qc_last,
  // formatted input toward the core
  output logic              out_valid,
  output logic [511:0]      out_data,
  output logic [63:0]       out_mask,
  output logic [63:0]       out_hard,
  output logic              out_last,
  output logic [1:0]        out_phase,
  // link
  lstab_if.dev              lnk
);
  localparam int SC_D = 1 << SC_AW;
  localparam int LA_D = 1 << LA_AW;
  localparam int QC_D = 1 << QC_AW;

  typedef struct packed {
    logic                    awready, wready, bvalid;
    logic                    arready, rvalid;
    logic [1:0]              bresp, rresp;
    logic [31:0]             rdata;
    logic                    aw_got, w_got;
    logic [17:0]             awaddr;
    logic [31:0]             wdata;
    logic [1:0]              width_cfg;
    logic                    words_mode, encode, pack_en, heavy;
    logic [15:0]             blk_len;
    logic [9:0]              submatrix_size;
    logic [7:0]              sc_off, la_off;
    logic [10:0]             qc_off;
    logic [15:0]             got, blk_cnt;
    logic                    din_ready;
    logic                    out_valid, out_last;
    logic [511:0]            out_data;
    logic [63:0]             out_mask, out_hard;
    logic [1:0]              out_phase;
    logic                    lk_valid;
    logic [3:0]              sc_factor;
    logic [15:0]             la_word;
    logic [18:0]             qc_word;
    logic [8:0]              qc_rot;
    logic                    qc_noop, qc_last;
    logic [SC_D-1:0][15:0]   sc;
    logic [LA_D-1:0][15:0]   la;
    logic [QC_D-1:0][18:0]   qc;
  } lstab_dev_type;

  lstab_dev_type st, next_st;

  // address falls in a region of the given base and word depth
  function automatic logic in_reg(input logic [17:0] a,
                                  input logic [17:0] base,
                                  input int aw);
    return a >= base && a < base + 18'((1 << aw) * 4);
  endfunction

  // lane enabled by the width setting
  function automatic logic lane_on(input logic [1:0] w, input int l);
    return l < (1 << w);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0]        rem;
    logic [7:0]         c;
    logic [15:0]        tot;
    logic [SC_AW-1:0]   si;
    logic [LA_AW-1:0]   li;
    logic [QC_AW-1:0]   qi;
    logic [17:0]        a;
    logic               take;
    rem = 16'h0;
    c = 8'h0;
    tot = 16'h0;
    si = '0;
    li = '0;
    qi = '0;
    a = 18'h0;
    take = 1'b0;
    next_st = st;
    // write channel: address and data in either order
    if (s_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_awaddr;
    end
    if (s_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_wdata;
    end
    if (st.bvalid && s_bready)
      next_st.bvalid = 1'b0;
    if (st.aw_got && st.w_got && !st.bvalid) begin
      a = st.awaddr;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `LSTAB_RESP_OK;
      // byte strobes are ignored: each table word is written whole
      if (a == `LSTAB_CTRL_OFS) begin
        next_st.width_cfg = st.wdata[1:0];
        next_st.words_mode = st.wdata[2];
        next_st.encode = st.wdata[3];
        next_st.pack_en = st.wdata[4];
        next_st.heavy = st.wdata[5];
      end else if (a == `LSTAB_BLKLEN_OFS) begin
        next_st.blk_len = st.wdata[15:0];
        next_st.got = 16'h0;
      end else if (a == `LSTAB_SUBMATRIX_SIZE_OFS) begin
        next_st.submatrix_size = st.wdata[9:0];
      end else if (a == `LSTAB_PTR_OFS) begin
        next_st.sc_off = st.wdata[7:0];
        next_st.la_off = st.wdata[15:8];
        next_st.qc_off = st.wdata[26:16];
      end else if (in_reg(a, `LSTAB_SC_BASE, SC_AW)) begin
        next_st.sc[a[SC_AW+1:2]] = st.wdata[15:0];
      end else if (in_reg(a, `LSTAB_LA_BASE, LA_AW)) begin
        next_st.la[a[LA_AW+1:2]] = st.wdata[15:0];
      end else if (in_reg(a, `LSTAB_QC_BASE, QC_AW)) begin
        next_st.qc[a[QC_AW+1:2]] = st.wdata[18:0];
      end else begin
        next_st.bresp = `LSTAB_RESP_ERR;
      end
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;
    // read channel
    if (st.rvalid && s_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_arvalid && st.arready) begin
      a = s_araddr;
      next_st.rvalid = 1'b1;
      next_st.rresp = `LSTAB_RESP_OK;
      next_st.rdata = 32'h0;
      if (a == `LSTAB_CTRL_OFS)
        next_st.rdata = {26'h0, st.heavy, st.pack_en, st.encode,
                         st.words_mode, st.width_cfg};
      else if (a == `LSTAB_BLKLEN_OFS)
        next_st.rdata = {16'h0, st.blk_len};
      else if (a == `LSTAB_SUBMATRIX_SIZE_OFS)
        next_st.rdata = {22'h0, st.submatrix_size};
      else if (a == `LSTAB_PTR_OFS)
        next_st.rdata = {5'h0, st.qc_off, st.la_off, st.sc_off};
      else if (a == `LSTAB_STAT_OFS)
        next_st.rdata = {st.blk_cnt, st.got};
      else if (in_reg(a, `LSTAB_SC_BASE, SC_AW))
        next_st.rdata = core_active ? 32'h0 :
                        {16'h0, st.sc[a[SC_AW+1:2]]};
      else if (in_reg(a, `LSTAB_LA_BASE, LA_AW))
        next_st.rdata = core_active ? 32'h0 :
                        {16'h0, st.la[a[LA_AW+1:2]]};
      else if (in_reg(a, `LSTAB_QC_BASE, QC_AW))
        next_st.rdata = core_active ? 32'h0 :
                        {13'h0, st.qc[a[QC_AW+1:2]]};
      else
        next_st.rresp = `LSTAB_RESP_ERR;
    end
    next_st.arready = !next_st.rvalid;
    // lookup: pointers from own register, wrapping index
    next_st.lk_valid = lk_req;
    if (lk_req) begin
      si = SC_AW'({2'h0, st.sc_off} + 10'(lk_layer >> 2));
      li = LA_AW'({st.la_off, 2'h0} + 10'(lk_layer));
      qi = QC_AW'({st.qc_off, 2'h0} + lk_op);
      next_st.sc_factor = 4'(st.sc[si] >> {lk_layer[1:0], 2'h0});
      next_st.la_word = st.la[li];
      next_st.qc_word = st.qc[qi];
      // wide submatrix or packing off: nine rotation bits
      if (st.submatrix_size > `LSTAB_SMALL_P || !st.pack_en) begin
        next_st.qc_rot = st.qc[qi][16:8];
        next_st.qc_noop = 1'b0;
        next_st.qc_last = 1'b0;
      end else begin
        next_st.qc_rot = {2'h0, st.qc[qi][14:8]};
        next_st.qc_noop = st.qc[qi][16];
        next_st.qc_last = st.qc[qi][15] &&
                          (st.encode || st.heavy);
      end
    end
    // input sink: trim counts lane by lane to the block remainder
    next_st.din_ready = st.blk_len != 16'h0;
    take = lnk.din_valid && lnk.words_valid && st.din_ready;
    next_st.out_valid = take;
    if (take) begin
      rem = st.blk_len - st.got;
      tot = 16'h0;
      next_st.out_data = lnk.din;
      for (int l = 0; l < `LSTAB_LANES; l++) begin
        c = st.words_mode ? lnk.words[8*l +: 8] : lnk.words[7:0];
        if (c > `LSTAB_LANE_MAX)
          c = `LSTAB_LANE_MAX;
        if (!lane_on(st.width_cfg, l))
          c = 8'h0;
        if (16'(c) > rem)
          c = rem[7:0];
        rem = rem - 16'(c);
        tot = tot + 16'(c);
        for (int b = 0; b < `LSTAB_LANE_BYTES; b++) begin
          next_st.out_mask[16*l+b] = b < int'(c);
          // encode and decode alike: hard bit is the inverted soft sign bit
          next_st.out_hard[16*l+b] = !lnk.din[128*l+8*b+7];
        end
      end
      // position of first byte within the three-value turbo cycle
      next_st.out_phase = 2'(st.got % 16'h3);
      if (st.got + tot >= st.blk_len) begin
        next_st.got = 16'h0;
        next_st.out_last = 1'b1;
        next_st.blk_cnt = st.blk_cnt + 16'h1;
      end else begin
        next_st.got = st.got + tot;
        next_st.out_last = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign s_awready   = st.awready;
  assign s_wready    = st.wready;
  assign s_bvalid    = st.bvalid;
  assign s_bresp     = st.bresp;
  assign s_arready   = st.arready;
  assign s_rvalid    = st.rvalid;
  assign s_rresp     = st.rresp;
  assign s_rdata     = st.rdata;
  assign lk_valid    = st.lk_valid;
  assign sc_factor   = st.sc_factor;
  assign la_stall    = st.la_word[15:8];
  assign la_heavy    = st.la_word[7];
  assign la_cycles   = st.la_word[6:0];
  assign qc_parity   = st.qc_word[18];
  assign qc_first    = st.qc_word[17];
  assign qc_col      = st.qc_word[7:0];
  assign qc_rot      = st.qc_rot;
  assign qc_noop     = st.qc_noop;
  assign qc_last     = st.qc_last;
  assign out_valid   = st.out_valid;
  assign out_data    = st.out_data;
  assign out_mask    = st.out_mask;
  assign out_hard    = st.out_hard;
  assign out_last    = st.out_last;
  assign out_phase   = st.out_phase;
  assign lnk.din_ready   = st.din_ready;
  assign lnk.words_ready = st.din_ready;
endmodule
`default_nettype wire

// ==== hdl/lstab_defs.svh ====
// constants of the shared code tables and soft-data input link
// assumes inclusion by bare name from the device, source and bench files
// Function
// - software leaves tables alone in 5G mode
// - per-code start pointers locate table entries
// - table addressing wraps to table base
// - software writes only entries no code uses
// - table reads return zero while core busy
// - scale word holds four 4-bit factors
// - layer word bits 15:8 start stall
// - layer word bit 7 heavy circulant handling
// - layer word bits 6:0 cycles minus one
// - circulant bit 18 parity, bit 17 first
// - column 7:0, rotation 16:8 above 128
// - small submatrix: no-op, last, rotation 14:8
// - negative soft value is hard zero
// - four 128-bit lanes, one/two/four enabled
// - source sends least significant values first
// - per-lane counts, bytes in low positions
// - last transfer trimmed, no block straddles
// - ldpc soft values saturated to 6 bits
// - turbo bytes cycle through three kinds
// - turbo source appends twelve tail values; lstab_src appends none
// - saturation limits 00011111 and 11100001
`ifndef LSTAB_DEFS_SVH
`define LSTAB_DEFS_SVH
// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define LSTAB_CTRL_OFS   18'h00000
`define LSTAB_BLKLEN_OFS 18'h00004
`define LSTAB_SUBMATRIX_SIZE_OFS  18'h00008
`define LSTAB_PTR_OFS    18'h0000C
`define LSTAB_STAT_OFS   18'h00010
`define LSTAB_SC_BASE    18'h10000
`define LSTAB_LA_BASE    18'h18000
`define LSTAB_QC_BASE    18'h20000
// ----------------------------------------------------------------
// fields and sizes
// ----------------------------------------------------------------
`define LSTAB_SC_AW      8
`define LSTAB_LA_AW      10
`define LSTAB_QC_AW      13
`define LSTAB_SMALL_P    10'h080
`define LSTAB_LANE_MAX   8'h10
`define LSTAB_LANES      4
`define LSTAB_LANE_BYTES 16
`define LSTAB_RESP_OK    2'h0
`define LSTAB_RESP_ERR   2'h2
`define LSTAB_LDPC_POS   8'h1F
`define LSTAB_LDPC_NEG   8'hE1
`define LSTAB_TURBO_NEG  8'h81
`define LSTAB_MOST_NEG   8'h80
`endif

// ==== hdl/lstab_pkg.sv ====
// shared types of the table and input link block
// assumes the defs header sits beside it
package lstab_pkg;
  // lane count setting, one, two or four lanes
  typedef enum logic [1:0] {
    LSTAB_W1 = 2'h0,
    LSTAB_W2 = 2'h1,
    LSTAB_W4 = 2'h2
  } lstab_width_type;
  // source saturation mode
  typedef enum logic [1:0] {
    LSTAB_SAT_NONE  = 2'h0,
    LSTAB_SAT_LDPC  = 2'h1,
    LSTAB_SAT_TURBO = 2'h2
  } lstab_sat_type;
  // source sequencer, one-hot
  typedef enum logic [1:0] {
    LSTAB_IDLE = 2'b01,
    LSTAB_SEND = 2'b10
  } lstab_state_type;
endpackage

// ==== hdl/lstab_if.sv ====
// link between data source and table/input device
// assumes both ends share one clock outside this carrier
`timescale 1ns/1ps
`default_nettype none
interface lstab_if;
  logic [511:0] din;
  logic         din_valid;
  logic         din_ready;
  logic [31:0]  words;
  logic         words_valid;
  logic         words_ready;
  modport dev (
    input  din,
    input  din_valid,
    output din_ready,
    input  words,
    input  words_valid,
    output words_ready
  );
  modport src (
    output din,
    output din_valid,
    input  din_ready,
    output words,
    output words_valid,
    input  words_ready
  );
endinterface
`default_nettype wire

// ==== hdl/lstab_src.sv ====
// data source end: saturates soft bytes and presents both streams
// assumes the user hands over values in block order, low first
`timescale 1ns/1ps
`default_nettype none
`include "lstab_defs.svh"
module lstab_src
  import lstab_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // user side
  input  wire logic [511:0] u_data,
  input  wire logic [31:0]  u_words,
  input  wire logic         u_words_mode,
  input  wire logic [1:0]   u_sat_mode,
  input  wire logic         u_valid,
  output logic              u_ready,
  // link
  lstab_if.src              lnk
);
  typedef struct packed {
    lstab_state_type  fsm;
    logic             u_ready;
    logic [511:0]     din;
    logic [31:0]      words;
    logic             dv, wv;
  } lstab_src_type;

  lstab_src_type st, next_st;

  // symmetric saturation of one soft byte
  function automatic logic [7:0] sat(input logic [7:0] v,
                                     input logic [1:0] m);
    logic signed [7:0] s;
    s = v;
    if (m == LSTAB_SAT_LDPC) begin
      if (s > $signed(`LSTAB_LDPC_POS))
        return `LSTAB_LDPC_POS;
      if (s < $signed(`LSTAB_LDPC_NEG))
        return `LSTAB_LDPC_NEG;
    end else if (m == LSTAB_SAT_TURBO) begin
      if (v == `LSTAB_MOST_NEG)
        return `LSTAB_TURBO_NEG;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] c;
    c = 8'h0;
    next_st = st;
    unique case (st.fsm)
      LSTAB_IDLE: begin
        if (u_valid && st.u_ready) begin
          // bytes keep user order, so low values go first
          for (int l = 0; l < `LSTAB_LANES; l++) begin
            c = u_words_mode ? u_words[8*l +: 8] : u_words[7:0];
            for (int b = 0; b < `LSTAB_LANE_BYTES; b++) begin
              // bytes above the lane count go out as zero
              next_st.din[128*l+8*b +: 8] = (b < int'(c)) ?
                sat(u_data[128*l+8*b +: 8], u_sat_mode) : 8'h0;
            end
          end
          next_st.words = u_words;
          next_st.dv = 1'b1;
          next_st.wv = 1'b1;
          next_st.fsm = LSTAB_SEND;
        end
      end
      LSTAB_SEND: begin
        // each stream is released on its own handshake
        if (st.dv && lnk.din_ready)
          next_st.dv = 1'b0;
        if (st.wv && lnk.words_ready)
          next_st.wv = 1'b0;
        if (!next_st.dv && !next_st.wv)
          next_st.fsm = LSTAB_IDLE;
      end
      default: next_st.fsm = LSTAB_IDLE;
    endcase
    next_st.u_ready = next_st.fsm == LSTAB_IDLE;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{fsm: LSTAB_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign u_ready         = st.u_ready;
  assign lnk.din         = st.din;
  assign lnk.din_valid   = st.dv;
  assign lnk.words       = st.words;
  assign lnk.words_valid = st.wv;
endmodule
`default_nettype wire

// ==== verif/lstab_assertions.sv ====
// link-level checks between data source and table/input device
// assumes instantiation in tb beside the interface, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lstab_checker (
  // clock and reset
  input wire logic         clk,
  input wire logic         rst_b,
  // link signals
  input wire logic [511:0] din,
  input wire logic         din_valid,
  input wire logic         din_ready,
  input wire logic [31:0]  words,
  input wire logic         words_valid,
  input wire logic         words_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // lane 0 bytes above the count, zero when the source is correct
  logic [127:0] above0;
  assign above0 = (words[7:0] > 8'h0F) ? 128'h0
                : (din[127:0] >> (8 * words[7:0]));
  // ----------------------------------------------------------------
  // handshake and framing
  // ----------------------------------------------------------------
  property p_din_hold;
    din_valid && !din_ready |=> din_valid && $stable(din);
  endproperty
  a_din_hold: assert property (p_din_hold)
    else $error("din changed before taken");
  property p_words_hold;
    words_valid && !words_ready |=> words_valid && $stable(words);
  endproperty
  a_words_hold: assert property (p_words_hold)
    else $error("words changed before taken");
  property p_ready_pair;
    din_ready == words_ready;
  endproperty
  a_ready_pair: assert property (p_ready_pair)
    else $error("ready signals differ");
  property p_valid_pair;
    $rose(din_valid) |-> $rose(words_valid);
  endproperty
  a_valid_pair: assert property (p_valid_pair)
    else $error("valid signals not raised together");
  property p_gap;
    din_valid && din_ready |=> !din_valid;
  endproperty
  a_gap: assert property (p_gap)
    else $error("source did not return to idle");
  property p_zero_above;
    din_valid |-> above0 == 128'h0;
  endproperty
  a_zero_above: assert property (p_zero_above)
    else $error("bytes above lane count not zero");
  property p_ready_stays;
    din_ready |=> din_ready;
  endproperty
  a_ready_stays: assert property (p_ready_stays)
    else $error("device dropped ready");
  property p_taken_soon;
    din_valid |-> ##[0:4] din_ready;
  endproperty
  a_taken_soon: assert property (p_taken_soon)
    else $error("transfer not taken in time");
  // main scenarios
  c_take: cover property (din_valid && din_ready);
  c_four: cover property (din_valid && din_ready && words[31:24] != 8'h00);
  c_end: cover property ($fell(din_valid));
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench: both link ends joined, axi4-lite and user side
// assumes the design files and defs header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "lstab_defs.svh"
module tb;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, core_active;
  logic lk_req, u_valid, u_words_mode, awready, wready, bvalid, arready;
  logic rvalid, lk_valid, la_heavy, qc_parity, qc_first, qc_noop, qc_last;
  logic out_valid, out_last, u_ready;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, u_words;
  logic [1:0] bresp, rresp, out_phase, u_sat_mode;
  logic [3:0] sc_factor;
  logic [7:0] la_stall, qc_col;
  logic [6:0] la_cycles;
  logic [8:0] lk_layer, qc_rot;
  logic [12:0] lk_op;
  logic [511:0] u_data, out_data;
  logic [63:0] out_mask, out_hard;
  int n_errors, tests_run, cycles;
  lstab_if u_lstab_if ();
  lstab_dev #(.SC_AW(4), .LA_AW(4), .QC_AW(6)) u_lstab_dev (
    .clk(clk), .rst_b(rst_b), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .core_active(core_active), .lk_req(lk_req), .lk_layer(lk_layer),
    .lk_op(lk_op), .lk_valid(lk_valid), .sc_factor(sc_factor),
    .la_stall(la_stall), .la_heavy(la_heavy), .la_cycles(la_cycles),
    .qc_parity(qc_parity), .qc_first(qc_first), .qc_col(qc_col),
    .qc_rot(qc_rot), .qc_noop(qc_noop), .qc_last(qc_last),
    .out_valid(out_valid), .out_data(out_data), .out_mask(out_mask),
    .out_hard(out_hard), .out_last(out_last), .out_phase(out_phase),
    .lnk(u_lstab_if.dev));
  lstab_src u_lstab_src (
    .clk(clk), .rst_b(rst_b), .u_data(u_data), .u_words(u_words),
    .u_words_mode(u_words_mode), .u_sat_mode(u_sat_mode),
    .u_valid(u_valid), .u_ready(u_ready), .lnk(u_lstab_if.src));
  lstab_checker u_lstab_checker (
    .clk(clk), .rst_b(rst_b), .din(u_lstab_if.din),
    .din_valid(u_lstab_if.din_valid), .din_ready(u_lstab_if.din_ready),
    .words(u_lstab_if.words), .words_valid(u_lstab_if.words_valid),
    .words_ready(u_lstab_if.words_ready));
  // ----------------------------------------------------------------
  // clock, timeout, shared tasks
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  // a hang in any wait ends here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // response taken only after both address and data were accepted
  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        r = bresp;
        done = 1;
      end
    end
    bready <= 0;
  endtask
  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        done = 1;
      end
    end
    rready <= 0;
  endtask
  task automatic lookup(input logic [8:0] l, input logic [12:0] o);
    @(posedge clk);
    lk_req <= 1;
    lk_layer <= l;
    lk_op <= o;
    @(posedge clk);
    lk_req <= 0;
    @(negedge clk);
    check("lk_valid", lk_valid, 1);
  endtask
  // waits for the formatted transfer, bounded
  task automatic send(input logic [511:0] d, input logic [31:0] w,
                      input logic m, input logic [1:0] s);
    int k;
    k = 0;
    @(posedge clk);
    u_data <= d;
    u_words <= w;
    u_words_mode <= m;
    u_sat_mode <= s;
    u_valid <= 1;
    do @(posedge clk); while (u_ready !== 1);
    u_valid <= 0;
    do begin
      @(negedge clk);
      k++;
    end while (out_valid !== 1 && k < 20);
    check("out_valid", out_valid, 1);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(`LSTAB_SC_BASE, 32'hFFFFFFFF, r);
    axi_rd(`LSTAB_SC_BASE, d, r);
    check("sc word", d, 32'h0000FFFF);
    axi_wr(`LSTAB_LA_BASE, 32'hFFFFFFFF, r);
    axi_rd(`LSTAB_LA_BASE, d, r);
    check("la word", d, 32'h0000FFFF);
    axi_wr(`LSTAB_QC_BASE, 32'hFFFFFFFF, r);
    axi_rd(`LSTAB_QC_BASE, d, r);
    check("qc word", d, 32'h0007FFFF);
    axi_wr(18'h08000, 32'h1, r);
    check("unmapped bresp", r, `LSTAB_RESP_ERR);
    axi_rd(18'h08000, d, r);
    check("unmapped rresp", r, `LSTAB_RESP_ERR);
    check("unmapped rdata", d, 32'h0);
  endtask
  task automatic t_busy;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    core_active <= 1;
    axi_rd(`LSTAB_SC_BASE, d, r);
    check("busy rdata", d, 32'h0);
    check("busy rresp", r, `LSTAB_RESP_OK);
    @(posedge clk);
    core_active <= 0;
    axi_rd(`LSTAB_SC_BASE, d, r);
    check("idle rdata", d, 32'h0000FFFF);
  endtask
  // pointers near the table tops so every index wraps
  task automatic t_lookup;
    logic [1:0] r;
    axi_wr(`LSTAB_PTR_OFS, 32'h000F030F, r);
    axi_wr(`LSTAB_SC_BASE, 32'h4321, r);
    axi_wr(`LSTAB_LA_BASE + 18'h4, 32'hA5C3, r);
    axi_wr(`LSTAB_QC_BASE + 18'h8, 32'h0007D5A3, r);
    axi_wr(`LSTAB_SUBMATRIX_SIZE_OFS, 32'h0C8, r);
    axi_wr(`LSTAB_CTRL_OFS, 32'h18, r);
    lookup(9'h5, 13'h6);
    check("sc_factor", sc_factor, 4'h2);
    check("la_stall", la_stall, 8'hA5);
    check("la_heavy", la_heavy, 1);
    check("la_cycles", la_cycles, 7'h43);
    check("qc flags", {qc_parity, qc_first}, 2'h3);
    check("qc_col", qc_col, 8'hA3);
    check("qc_rot big", {qc_noop, qc_last, qc_rot}, 11'h1D5);
    axi_wr(`LSTAB_SUBMATRIX_SIZE_OFS, 32'h040, r);
    lookup(9'h5, 13'h6);
    check("qc_rot small", {qc_noop, qc_last, qc_rot}, 11'h655);
  endtask
  // 26-byte block on four lanes: 16 then 10 trimmed, then a new block
  task automatic t_link;
    logic [1:0] r;
    logic [63:0] m1, h;
    logic [31:0] d;
    m1 = 64'h0003_0003_000F_00FF;
    h = ~m1 | 64'h5555_5555_5555_5555;
    axi_wr(`LSTAB_CTRL_OFS, 32'h6, r);
    axi_wr(`LSTAB_BLKLEN_OFS, 32'd26, r);
    for (int i = 0; i < 3; i++) begin
      send({32{16'h8001}}, 32'h02020408, 1'b1, 2'h0);
      check("mask", out_mask, (i == 1) ? 64'h3_00FF : m1);
      check("last", out_last, i == 1);
      check("phase", out_phase, (i == 1) ? 2'h1 : 2'h0);
      check("hard", out_hard, h);
      check("lane0", out_data[63:0], {4{16'h8001}});
      check("lane0 top", out_data[127:64], 64'h0);
    end
    axi_rd(`LSTAB_STAT_OFS, d, r);
    check("status", d, 32'h0001_0010);
  endtask
  task automatic t_sat;
    logic [1:0] r;
    axi_wr(`LSTAB_CTRL_OFS, 32'h0, r);
    axi_wr(`LSTAB_BLKLEN_OFS, 32'd2, r);
    send({{496{1'b1}}, 16'h807F}, 32'h2, 1'b0, 2'h1);
    check("ldpc sat", out_data[15:0], 16'hE11F);
    check("one lane", out_mask, 64'h3);
    send({{496{1'b1}}, 16'h807F}, 32'h2, 1'b0, 2'h2);
    check("turbo sat", out_data[15:0], 16'h817F);
  endtask
  initial begin
    {clk, rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    {core_active, lk_req, u_valid, u_words_mode, u_sat_mode} = '0;
    {awaddr, araddr, wdata, u_words, lk_layer, lk_op, u_data} = '0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    t_regs();
    t_busy();
    t_lookup();
    t_link();
    t_sat();
    report_and_stop();
  end
endmodule
`default_nettype wire
